/* File: pwel_pkg.sv */
package pwel_pkg;

  localparam int unsigned ADDR_W = 12;

  // Byte addresses of the register words.
  localparam logic [11:0] OFF_CTRL     = 12'h140;
  localparam logic [11:0] OFF_ADDR_LOG = 12'h144;
  localparam logic [11:0] OFF_DATA_LOG = 12'h148;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h14C;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h150;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h154;

  // Control word field positions.
  localparam int unsigned BIT_LOG_EN  = 31;
  localparam int unsigned BIT_ES      = 24;
  localparam int unsigned BIT_UNLOCK  = 23;
  localparam int unsigned CMD_LSB     = 4;
  localparam int unsigned BE_LSB      = 0;

  // Interrupt status bit positions.
  localparam int unsigned IRQ_BIT_ERR    = 0;
  localparam int unsigned IRQ_BIT_IGNORE = 1;
  localparam int unsigned IRQ_W          = 2;

  // Values after reset; CMD_LOG_RESET is the power-up value of the command log.
  localparam logic [3:0]  CMD_LOG_RESET = 4'h7;
  localparam logic [3:0]  BE_LOG_RESET  = 4'h0;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  // PCI command codes of the memory-space writes that can be posted.
  localparam logic [3:0] CMD_MEM_WRITE    = 4'h7;
  localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hF;

  // One finished posted write as reported by the PCI master.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic        target_abort;
    logic        master_abort;
  } write_result_s;

endpackage

/* File: pwel_capture.sv */
`timescale 1ns/1ps
`default_nettype none

module pwel_capture
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    clk_en,
  input  wire logic                    done,
  input  wire pwel_pkg::write_result_s result,
  input  wire logic                    log_en,
  input  wire logic                    frozen,
  output logic                         capture,
  output logic                         ignored
);

  wire is_mem_write = (result.cmd == pwel_pkg::CMD_MEM_WRITE) ||
                      (result.cmd == pwel_pkg::CMD_MEM_WRITE_INV);
  wire aborted      = result.target_abort || result.master_abort;
  wire failed       = done && aborted && is_mem_write;
  wire next_capture = failed && log_en && !frozen;
  // A failure seen while logging is enabled but the log is frozen is not logged but is reported.
  wire next_ignored = failed && log_en && frozen;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      capture <= 1'b0;
      ignored <= 1'b0;
    end
    else if (clk_en)
    begin
      capture <= next_capture;
      ignored <= next_ignored;
    end
  end

endmodule
`default_nettype wire

/* File: posted_write_error_logger.sv */
`timescale 1ns/1ps
`default_nettype none

module posted_write_error_logger
(
  input  wire logic                    CORE_CLK,
  input  wire logic                    ARST_N,
  input  wire logic                    CLK_EN,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    WR_DONE,
  input  wire pwel_pkg::write_result_s WR_RESULT,
  output logic                         SLAVE_CHANNEL_HOLD,
  output logic                         ERR_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic        log_en;
  logic        error_status_flag;
  logic        slave_channel_unlock;
  // Declared with its power-up value so that only the capture process ever writes it.
  logic [3:0]  cmd_log = pwel_pkg::CMD_LOG_RESET;
  logic [3:0]  failed_byte_lane_log;
  logic [31:0] failed_address_log;
  logic [31:0] failed_data_log;
  logic [pwel_pkg::IRQ_W-1:0] irq_stat;
  logic [pwel_pkg::IRQ_W-1:0] irq_en;
  logic        capture;
  logic        ignored;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. The slave answers in the first access cycle.

  wire setup_ok = PSEL && !PENABLE;
  wire wr_acc   = PSEL && PENABLE && PWRITE && PREADY;
  wire rd_setup = setup_ok && !PWRITE;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  wire sel_ctrl  = hit(PADDR, pwel_pkg::OFF_CTRL);
  wire sel_addr  = hit(PADDR, pwel_pkg::OFF_ADDR_LOG);
  wire sel_data  = hit(PADDR, pwel_pkg::OFF_DATA_LOG);
  wire sel_stat  = hit(PADDR, pwel_pkg::OFF_IRQ_STAT);
  wire sel_en    = hit(PADDR, pwel_pkg::OFF_IRQ_EN);
  wire sel_clr   = hit(PADDR, pwel_pkg::OFF_IRQ_CLR);
  wire mapped    = sel_ctrl | sel_addr | sel_data | sel_stat | sel_en | sel_clr;

  wire wr_ctrl   = wr_acc && sel_ctrl;
  wire wr_en     = wr_acc && sel_en;
  wire wr_clr    = wr_acc && sel_clr;
  // Writing 0 to log enable and 1 to the flag in one word is the safe way to stop logging.
  wire es_w1c    = wr_ctrl && PWDATA[pwel_pkg::BIT_ES];

  ////////////////////////////////////////////////////////////////////////////
  // Read view: byte-lane, address and data logs read as zero while nothing is held.

  wire [3:0]  be_view   = error_status_flag ? failed_byte_lane_log : 4'h0;
  wire [31:0] addr_view = error_status_flag ? failed_address_log : 32'h0000_0000;
  wire [31:0] data_view = error_status_flag ? failed_data_log : 32'h0000_0000;

  logic [31:0] ctrl_word;
  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[pwel_pkg::BIT_LOG_EN] = log_en;
    ctrl_word[pwel_pkg::BIT_ES] = error_status_flag;
    ctrl_word[pwel_pkg::BIT_UNLOCK] = slave_channel_unlock;
    ctrl_word[pwel_pkg::CMD_LSB +: 4] = cmd_log;
    ctrl_word[pwel_pkg::BE_LSB +: 4] = be_view;
  end

  wire [31:0] irq_stat_word = {{(32 - pwel_pkg::IRQ_W){1'b0}}, irq_stat};
  wire [31:0] irq_en_word   = {{(32 - pwel_pkg::IRQ_W){1'b0}}, irq_en};

  wire [31:0] next_rdata = sel_ctrl ? ctrl_word :
                           sel_addr ? addr_view :
                           sel_data ? data_view :
                           sel_stat ? irq_stat_word :
                           sel_en   ? irq_en_word : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Failure detection.

  pwel_capture u_capture
  (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .clk_en  (CLK_EN),
    .done    (WR_DONE),
    .result  (WR_RESULT),
    .log_en  (log_en),
    // A capture in flight freezes too, or a failure one cycle later would overwrite the log.
    .frozen  (error_status_flag || capture),
    .capture (capture),
    .ignored (ignored)
  );

  // The result is held one cycle so that all logs come from the same transfer.
  pwel_pkg::write_result_s held;
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      held <= '0;
    else if (CLK_EN && WR_DONE)
      held <= WR_RESULT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status.

  wire next_flag = capture ? 1'b1 : (es_w1c ? 1'b0 : error_status_flag);

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      log_en               <= 1'b0;
      slave_channel_unlock <= 1'b0;
      error_status_flag    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (wr_ctrl)
      begin
        log_en               <= PWDATA[pwel_pkg::BIT_LOG_EN];
        slave_channel_unlock <= PWDATA[pwel_pkg::BIT_UNLOCK];
      end
      error_status_flag <= next_flag;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      failed_address_log   <= pwel_pkg::WORD_RESET;
      failed_data_log      <= pwel_pkg::WORD_RESET;
      failed_byte_lane_log <= pwel_pkg::BE_LOG_RESET;
    end
    else if (CLK_EN && capture)
    begin
      failed_address_log   <= held.addr;
      failed_data_log      <= held.data;
      failed_byte_lane_log <= held.be_n;
    end
  end

  // The command log is outside the global reset: it holds its value until the next capture.
  always_ff @(posedge CORE_CLK)
  begin
    if (CLK_EN && capture)
      cmd_log <= held.cmd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts. Status bits are sticky; a hardware set wins over a clear.

  wire [pwel_pkg::IRQ_W-1:0] irq_set;
  assign irq_set[pwel_pkg::IRQ_BIT_ERR]    = capture;
  assign irq_set[pwel_pkg::IRQ_BIT_IGNORE] = ignored;
  wire [pwel_pkg::IRQ_W-1:0] irq_clr = wr_clr ? PWDATA[pwel_pkg::IRQ_W-1:0] : '0;
  wire [pwel_pkg::IRQ_W-1:0] next_irq_stat = irq_set | (irq_stat & ~irq_clr);
  // Routing to the pin works only while logging is enabled.
  wire next_irq = log_en && |(next_irq_stat & irq_en);

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      irq_stat <= '0;
      irq_en   <= '0;
      ERR_IRQ  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      irq_stat <= next_irq_stat;
      if (wr_en)
        irq_en <= PWDATA[pwel_pkg::IRQ_W-1:0];
      ERR_IRQ <= wr_ctrl ? (PWDATA[pwel_pkg::BIT_LOG_EN] && |(next_irq_stat & irq_en))
                         : next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave channel hold and bus answer.

  wire next_hold = next_flag &&
                   !(wr_ctrl ? PWDATA[pwel_pkg::BIT_UNLOCK] : slave_channel_unlock);

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      SLAVE_CHANNEL_HOLD <= 1'b0;
      PREADY             <= 1'b0;
      PSLVERR            <= 1'b0;
      PRDATA             <= 32'h0000_0000;
    end
    else if (CLK_EN)
    begin
      SLAVE_CHANNEL_HOLD <= next_hold;
      PREADY             <= setup_ok;
      PSLVERR            <= setup_ok && !mapped;
      if (rd_setup)
        PRDATA <= next_rdata;
    end
  end

endmodule
`default_nettype wire

/* File: pwel_props.sv */
`timescale 1ns/1ps
`default_nettype none

module pwel_props
(
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  input wire logic        CLK_EN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        WR_DONE,
  input wire logic        SLAVE_CHANNEL_HOLD,
  input wire logic        ERR_IRQ
);
  logic wr;
  logic h;
  assign wr = PREADY && PWRITE;
  assign h = SLAVE_CHANNEL_HOLD;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  a_ready_after_setup: assert property (PSEL && !PENABLE && CLK_EN |=> PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY && CLK_EN |=> !PREADY)
    else $error("ready longer than one cycle");
  a_unmapped_read_zero: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
    else $error("bad unmapped answer");
  a_hold_has_cause: assert property ($rose(h) |-> $past(WR_DONE, 2) || $past(wr) || $past(wr, 2))
    else $error("hold rose without cause");
  a_irq_has_cause: assert property ($rose(ERR_IRQ) |-> $past(WR_DONE, 2) || $past(wr) || $past(wr, 2))
    else $error("irq rose without cause");
  a_hold_until_write: assert property ($fell(h) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("hold fell without write");
  a_irq_until_write: assert property ($fell(ERR_IRQ) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("irq fell without write");
  a_reset_quiet: assert property ($rose(ARST_N) |-> !PREADY && !h && !ERR_IRQ)
    else $error("outputs active after reset");
endmodule

`default_nettype wire

/* File: pci_target_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pci_target_model
(
  input  wire logic                    clk,
  input  wire logic                    start,
  input  wire pwel_pkg::write_result_s req,
  input  wire logic [3:0]              wait_cycles,
  output logic                         done,
  output pwel_pkg::write_result_s      result
);
  logic [3:0] cnt = 4'h0;
  logic       busy = 1'b0;
  initial done = 1'b0;
  initial result = '0;

  // While idle the result lines toggle (done stays low), so a stale value is never taken for a real one.
  always @(posedge clk)
  begin
    done <= 1'b0;
    if (start && !busy)
    begin
      busy <= 1'b1;
      cnt <= wait_cycles;
      result <= req;
    end
    else if (busy && cnt == 4'h0)
    begin
      done <= 1'b1;
      busy <= 1'b0;
    end
    else if (busy)
      cnt <= cnt - 4'h1;
    else
      result <= ~result;
  end
endmodule

`default_nettype wire

/* File: tb_posted_write_error_logger.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_posted_write_error_logger;
  typedef struct {logic [3:0] cmd; logic ta; logic ma; logic hit; logic [3:0] dly;} row_s;
  logic                    CORE_CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0]             PADDR = '0;
  logic [31:0]             PWDATA = '0, PRDATA, rd, a;
  logic                    PREADY, PSLVERR, WR_DONE, SLAVE_CHANNEL_HOLD, ERR_IRQ, err, start = 0;
  logic                    CLK_EN = 1;
  logic [3:0]              dly = 0, cmdlog = 4'h7;
  pwel_pkg::write_result_s req = '0, WR_RESULT;
  int                      error_cnt = 0, n_checks = 0;
  row_s                    rows [5] = '{'{4'h7, 1, 0, 1, 4'h0}, '{4'hF, 0, 1, 1, 4'h3},
    '{4'h6, 1, 0, 0, 4'h0}, '{4'h7, 0, 0, 0, 4'h1}, '{4'h2, 0, 1, 0, 4'h0}};

  always #12.5 CORE_CLK = ~CORE_CLK;
  posted_write_error_logger dut (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .WR_DONE(WR_DONE),
    .WR_RESULT(WR_RESULT), .SLAVE_CHANNEL_HOLD(SLAVE_CHANNEL_HOLD), .ERR_IRQ(ERR_IRQ));
  pci_target_model far (.clk(CORE_CLK), .start(start), .req(req), .wait_cycles(dly),
    .done(WR_DONE), .result(WR_RESULT));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= ad; PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR t=%0t no bus answer", $time);
      tally_and_finish();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
    @(posedge CORE_CLK);
  endtask

  // The wait covers the documented latency from report to hold and interrupt.
  task automatic fail(input row_s r, input logic [31:0] ad);
    int n;
    req <= '{ad, ~ad, r.cmd, 4'h5, r.ta, r.ma}; dly <= r.dly; start <= 1;
    @(posedge CORE_CLK);
    start <= 0;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (WR_DONE !== 1'b1 && n < 30);
    if (WR_DONE !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR t=%0t no write report", $time);
      tally_and_finish();
    end
    repeat (4) @(posedge CORE_CLK);
  endtask

  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    ARST_N <= 1;
    apb(0, pwel_pkg::OFF_CTRL, 0); chk(rd, 32'h70);
    apb(1, pwel_pkg::OFF_IRQ_EN, 1);
    apb(1, pwel_pkg::OFF_CTRL, 32'h8000_0000);
    foreach (rows[i])
    begin
      a = 32'hC0DE_0000 + i;
      fail(rows[i], a);
      if (rows[i].hit)
        cmdlog = rows[i].cmd;
      chk(SLAVE_CHANNEL_HOLD, rows[i].hit);
      chk(ERR_IRQ, rows[i].hit);
      apb(0, pwel_pkg::OFF_CTRL, 0);
      chk(rd, {1'b1, 6'h0, rows[i].hit, 16'h0, cmdlog, rows[i].hit ? 4'h5 : 4'h0});
      apb(0, pwel_pkg::OFF_ADDR_LOG, 0); chk(rd, rows[i].hit ? a : 32'h0);
      apb(0, pwel_pkg::OFF_DATA_LOG, 0); chk(rd, rows[i].hit ? ~a : 32'h0);
      apb(1, pwel_pkg::OFF_CTRL, 32'h8100_0000);
      apb(1, pwel_pkg::OFF_IRQ_CLR, 3);
      apb(0, pwel_pkg::OFF_ADDR_LOG, 0); chk(rd, 0);
      chk({ERR_IRQ, SLAVE_CHANNEL_HOLD}, 0);
    end
    fail(rows[0], 32'h1111_1111);
    fail(rows[1], 32'h2222_2222);
    apb(1, pwel_pkg::OFF_ADDR_LOG, '1);
    apb(0, pwel_pkg::OFF_ADDR_LOG, 0); chk(rd, 32'h1111_1111);
    apb(0, pwel_pkg::OFF_IRQ_STAT, 0); chk(rd, 3);
    apb(1, pwel_pkg::OFF_CTRL, 32'h8080_0000);
    apb(0, 12'h158, 0); chk(err, 1); chk(rd, 0);
    chk(SLAVE_CHANNEL_HOLD, 0);
    apb(1, pwel_pkg::OFF_CTRL, 32'h0100_0000);
    apb(1, pwel_pkg::OFF_IRQ_CLR, 3);
    apb(0, pwel_pkg::OFF_CTRL, 0); chk(rd, 32'h70);
    fail(rows[1], a);
    chk({ERR_IRQ, SLAVE_CHANNEL_HOLD}, 0);
    apb(1, pwel_pkg::OFF_IRQ_EN, 0);
    apb(1, pwel_pkg::OFF_CTRL, 32'h8000_0000);
    fail(rows[1], a);
    chk({ERR_IRQ, SLAVE_CHANNEL_HOLD}, 1);
    apb(1, pwel_pkg::OFF_IRQ_EN, 1);
    apb(0, pwel_pkg::OFF_IRQ_EN, 0); chk(ERR_IRQ, 1); chk(rd, 1);
    // A report that arrives while the clock enable is low must leave no trace.
    apb(1, pwel_pkg::OFF_CTRL, 32'h8100_0000);
    CLK_EN <= 0;
    fail(rows[0], 32'h3333_3333);
    CLK_EN <= 1;
    chk(SLAVE_CHANNEL_HOLD, 0);
    apb(0, pwel_pkg::OFF_CTRL, 0); chk(rd, 32'h8000_00F0);
    ARST_N <= 0;
    @(posedge CORE_CLK);
    ARST_N <= 1;
    apb(0, pwel_pkg::OFF_CTRL, 0); chk(rd, 32'hF0);
    tally_and_finish();
  end
endmodule

bind posted_write_error_logger pwel_props chk_props
(
  .CORE_CLK           (CORE_CLK),
  .ARST_N             (ARST_N),
  .CLK_EN             (CLK_EN),
  .PSEL               (PSEL),
  .PENABLE            (PENABLE),
  .PWRITE             (PWRITE),
  .PRDATA             (PRDATA),
  .PREADY             (PREADY),
  .PSLVERR            (PSLVERR),
  .WR_DONE            (WR_DONE),
  .SLAVE_CHANNEL_HOLD (SLAVE_CHANNEL_HOLD),
  .ERR_IRQ            (ERR_IRQ)
);

`default_nettype wire
